// ===== bls_pkg.sv
// Shared constants and types of the black level and digital shift stage
package bls_pkg;

  // ==========================================================
  // Product variants
  typedef enum logic [1:0] {
    BLS_VAR_STD  = 2'b00,
    BLS_VAR_RED  = 2'b01,
    BLS_VAR_FINE = 2'b10
  } bls_variant_t;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_BLACK  = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;

  // ==========================================================
  // Field positions
  localparam int CTRL_WIDE_BIT  = 0;
  localparam int CTRL_SHIFT_LSB = 4;
  localparam int STAT_BLACK_LSB = 8;
  localparam int STAT_VAR_LSB   = 24;

  // ==========================================================
  // Reset values
  localparam logic       WIDE_RST  = 1'b0;
  localparam logic [2:0] SHIFT_RST = 3'h0;
  localparam logic [9:0] BLACK_RST = 10'h000;
  localparam logic [9:0] BL_REF_DEF = 10'h000;

  // ==========================================================
  // Ranges and scales
  localparam logic [2:0]  SHIFT_MAX   = 3'h4;
  localparam logic [9:0]  BL_MAX_STD  = 10'h0ff;
  localparam logic [9:0]  BL_MAX_RED  = 10'h040;
  localparam logic [9:0]  BL_MAX_FINE = 10'h3ff;
  localparam logic [11:0] FS_WIDE     = 12'hfff;
  localparam logic [11:0] FS_NARROW   = 12'h0ff;

  // ==========================================================
  // Black level step as a right shift (step = 2**n)
  localparam logic [2:0] STEP_STD8   = 3'h4;
  localparam logic [2:0] STEP_STD12  = 3'h0;
  localparam logic [2:0] STEP_RED    = 3'h2;
  localparam logic [2:0] STEP_FINE8  = 3'h6;
  localparam logic [2:0] STEP_FINE12 = 3'h2;

endpackage

// ===== bls_pix_if.sv
// Pixel stream carrier between the stage's internal modules
interface bls_pix_if;
  logic        valid;
  logic        sof;
  logic        sat;
  logic [11:0] data;

  modport src (output valid, output sof, output sat, output data);
  modport snk (input valid, input sof, input sat, input data);
endinterface

// ===== bls_shift_sat.sv
// Digital shift window selection with saturation, one register stage
module bls_shift_sat (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       nrst,
  // Settings for the pixel now on the input
  input  wire logic [2:0] shift,
  input  wire logic       wide,
  // Pixel streams
  bls_pix_if.snk          pin,
  bls_pix_if.src          pout
);

  typedef struct packed {
    logic        valid;
    logic        sof;
    logic        sat;
    logic [11:0] data;
  } bls_ss_t;

  bls_ss_t     r_q;
  bls_ss_t     r_d;
  logic [15:0] shifted;
  logic        ovf;

  // ==========================================================
  // Window selection
  always_comb begin
    shifted   = {4'h0, pin.data} << shift;
    ovf       = |shifted[15:12];
    r_d       = r_q;
    r_d.valid = pin.valid;
    r_d.sof   = pin.sof;
    r_d.sat   = 1'b0;
    if (pin.valid) begin
      r_d.sat = ovf;
      if (ovf) begin
        r_d.data = wide ? bls_pkg::FS_WIDE : bls_pkg::FS_NARROW;
      end else if (wide) begin
        r_d.data = shifted[11:0];
      end else begin
        r_d.data = {4'h0, shifted[11:4]};
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r_q <= '0;
    end else begin
      r_q <= r_d;
    end
  end

  assign pout.valid = r_q.valid;
  assign pout.sof   = r_q.sof;
  assign pout.sat   = r_q.sat;
  assign pout.data  = r_q.data;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_sat_all_ones;
    pin.valid && (shift != 3'h0) && |(pin.data >> (4'hc - {1'b0, shift}))
      |=> pout.sat && (pout.data == ($past(wide) ? 12'hfff : 12'h0ff));
  endproperty
  a_sat_all_ones: assert property (p_sat_all_ones)
    else $error("overflowing pixel not forced to all ones");

  property p_wide_passthru;
    pin.valid && wide && (shift == 3'h0) |=> pout.data == $past(pin.data);
  endproperty
  a_wide_passthru: assert property (p_wide_passthru)
    else $error("unshifted wide pixel altered");

  property p_shift1_even;
    pin.valid && wide && (shift == 3'h1) && !pin.data[11]
      |=> pout.data == {$past(pin.data[10:0]), 1'b0};
  endproperty
  a_shift1_even: assert property (p_shift1_even)
    else $error("shift by one window wrong");

  property p_narrow_window;
    pin.valid && !wide && (shift == 3'h0)
      |=> pout.data == {4'h0, $past(pin.data[11:4])};
  endproperty
  a_narrow_window: assert property (p_narrow_window)
    else $error("narrow window wrong");

endmodule // bls_shift_sat

// ===== bls_black_level_shift.sv
// Black level offset and digital shift stage of the pixel datapath
//
// The strobed register port and the register addresses were decided locally.
module bls_black_level_shift #(
  parameter bls_pkg::bls_variant_t VARIANT = bls_pkg::BLS_VAR_STD,
  parameter logic [9:0]            BL_REF  = bls_pkg::BL_REF_DEF
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [31:0] regRdata,
  // Samples from the ADC
  input  wire logic        adcValid,
  input  wire logic        adcSof,
  input  wire logic [11:0] adcData,
  // Pixels to the transmit path
  output logic             pixValid,
  output logic             pixSof,
  output logic      [11:0] pixData
);

  typedef struct packed {
    logic        wide;
    logic [2:0]  shift;
    logic [9:0]  black;
    logic        actWide;
    logic [2:0]  actShift;
    logic [9:0]  actBlack;
    logic [31:0] rdata;
    logic        oValid;
    logic        oSof;
    logic [11:0] oData;
  } bls_state_t;

  bls_state_t         r_q;
  bls_state_t         r_d;
  bls_pix_if          inIf ();
  bls_pix_if          stgIf ();

  logic [9:0]         blMax;
  logic [2:0]         stepSh;
  logic [11:0]        fullScale;
  logic               frameHit;
  logic [2:0]         effShift;
  logic               effWide;
  logic [2:0]         wrShift;
  logic [2:0]         shiftClip;
  logic [9:0]         blackClip;
  logic signed [10:0] diff;
  logic signed [10:0] offs;
  logic signed [13:0] sum;
  logic [11:0]        sumLow;
  logic [11:0]        clamped;

  // ==========================================================
  // Variant dependent range and step, width dependent full scale
  always_comb begin
    unique case (VARIANT)
      bls_pkg::BLS_VAR_RED: begin
        blMax  = bls_pkg::BL_MAX_RED;
        stepSh = bls_pkg::STEP_RED;
      end
      bls_pkg::BLS_VAR_FINE: begin
        blMax  = bls_pkg::BL_MAX_FINE;
        stepSh = r_q.actWide ? bls_pkg::STEP_FINE12
                             : bls_pkg::STEP_FINE8;
      end
      default: begin
        blMax  = bls_pkg::BL_MAX_STD;
        stepSh = r_q.actWide ? bls_pkg::STEP_STD12
                             : bls_pkg::STEP_STD8;
      end
    endcase
    fullScale = r_q.actWide ? bls_pkg::FS_WIDE : bls_pkg::FS_NARROW;
  end

  // ==========================================================
  // Write value conditioning
  always_comb begin
    wrShift = regWdata[bls_pkg::CTRL_SHIFT_LSB +: 3];
    if (VARIANT == bls_pkg::BLS_VAR_RED) begin
      shiftClip = 3'h0;
    end else if (wrShift > bls_pkg::SHIFT_MAX) begin
      shiftClip = bls_pkg::SHIFT_MAX;
    end else begin
      shiftClip = wrShift;
    end
    if ((|regWdata[31:10]) || (regWdata[9:0] > blMax)) begin
      blackClip = blMax;
    end else begin
      blackClip = regWdata[9:0];
    end
  end

  // ==========================================================
  // Shift stage; the frame's first pixel already uses new settings
  assign frameHit = adcValid && adcSof;
  assign effShift = frameHit ? r_q.shift : r_q.actShift;
  assign effWide  = frameHit ? r_q.wide : r_q.actWide;

  assign inIf.valid = adcValid;
  assign inIf.sof   = adcSof;
  assign inIf.sat   = 1'b0;
  assign inIf.data  = adcData;

  bls_shift_sat u_shift (
    .clk   (clk),
    .nrst  (nrst),
    .shift (effShift),
    .wide  (effWide),
    .pin   (inIf.snk),
    .pout  (stgIf.src)
  );

  // ==========================================================
  // Signed black level offset, scaled to output counts
  always_comb begin
    diff   = $signed({1'b0, r_q.actBlack}) - $signed({1'b0, BL_REF});
    offs   = diff >>> stepSh;
    sum    = $signed({2'b00, stgIf.data}) + $signed({{3{offs[10]}}, offs});
    sumLow = sum[11:0];
    if (stgIf.sat) begin
      clamped = fullScale;
    end else if (sum[13]) begin
      clamped = 12'h000;
    end else if (sum[12:0] > {1'b0, fullScale}) begin
      clamped = fullScale;
    end else begin
      clamped = sumLow;
    end
  end

  // ==========================================================
  // Registers, frame boundary update, output stage
  always_comb begin
    r_d       = r_q;
    r_d.rdata = 32'h0000_0000;
    if (regWr) begin
      case (regAddr)
        bls_pkg::ADDR_CTRL: begin
          r_d.wide  = regWdata[bls_pkg::CTRL_WIDE_BIT];
          r_d.shift = shiftClip;
        end
        bls_pkg::ADDR_BLACK: begin
          r_d.black = blackClip;
        end
        default: begin
        end
      endcase
    end
    if (regRd) begin
      case (regAddr)
        bls_pkg::ADDR_CTRL: begin
          r_d.rdata[bls_pkg::CTRL_WIDE_BIT]       = r_q.wide;
          r_d.rdata[bls_pkg::CTRL_SHIFT_LSB +: 3] = r_q.shift;
        end
        bls_pkg::ADDR_BLACK: begin
          r_d.rdata[9:0] = r_q.black;
        end
        bls_pkg::ADDR_STATUS: begin
          r_d.rdata[bls_pkg::CTRL_WIDE_BIT]        = r_q.actWide;
          r_d.rdata[bls_pkg::CTRL_SHIFT_LSB +: 3]  = r_q.actShift;
          r_d.rdata[bls_pkg::STAT_BLACK_LSB +: 10] = r_q.actBlack;
          r_d.rdata[bls_pkg::STAT_VAR_LSB +: 2]    = VARIANT;
        end
        default: begin
        end
      endcase
    end
    if (frameHit) begin
      r_d.actWide  = r_q.wide;
      r_d.actShift = r_q.shift;
      r_d.actBlack = r_q.black;
    end
    r_d.oValid = stgIf.valid;
    r_d.oSof   = stgIf.valid && stgIf.sof;
    if (stgIf.valid) begin
      r_d.oData = clamped;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r_q          <= '0;
      r_q.wide     <= bls_pkg::WIDE_RST;
      r_q.shift    <= bls_pkg::SHIFT_RST;
      r_q.black    <= bls_pkg::BLACK_RST;
      r_q.actWide  <= bls_pkg::WIDE_RST;
      r_q.actShift <= bls_pkg::SHIFT_RST;
      r_q.actBlack <= bls_pkg::BLACK_RST;
    end else begin
      r_q <= r_d;
    end
  end

  assign regRdata = r_q.rdata;
  assign pixValid = r_q.oValid;
  assign pixSof   = r_q.oSof;
  assign pixData  = r_q.oData;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_black_range;
    r_q.black <= blMax && r_q.actBlack <= blMax;
  endproperty
  a_black_range: assert property (p_black_range)
    else $error("black level outside allowed range");

  property p_fine_range;
    regWr && (regAddr == 8'h04) && (VARIANT == bls_pkg::BLS_VAR_FINE)
      && (regWdata == 32'h0000_03ff) |=> r_q.black == 10'h3ff;
  endproperty
  a_fine_range: assert property (p_fine_range)
    else $error("fine variant refuses full black level range");

  property p_reduced_no_shift;
    (VARIANT == bls_pkg::BLS_VAR_RED) |-> r_q.shift == 3'h0
      && r_q.actShift == 3'h0;
  endproperty
  a_reduced_no_shift: assert property (p_reduced_no_shift)
    else $error("shift active in reduced variant");

  property p_shift_decode;
    regWr && (regAddr == 8'h00) && (VARIANT != bls_pkg::BLS_VAR_RED)
      && (regWdata[6:4] == 3'h2) |=> r_q.shift == 3'h2;
  endproperty
  a_shift_decode: assert property (p_shift_decode)
    else $error("shift code not decoded");

  property p_hold_in_frame;
    !frameHit |=> $stable(r_q.actShift) && $stable(r_q.actBlack)
      && $stable(r_q.actWide);
  endproperty
  a_hold_in_frame: assert property (p_hold_in_frame)
    else $error("settings changed inside a frame");

  property p_take_at_frame;
    frameHit |=> r_q.actBlack == $past(r_q.black)
      && r_q.actShift == $past(r_q.shift);
  endproperty
  a_take_at_frame: assert property (p_take_at_frame)
    else $error("settings not taken at frame start");

  property p_offset_added;
    stgIf.valid && !stgIf.sat && !sum[13] && (sum[12:0] <= {1'b0, fullScale})
      |=> pixValid && pixData == $past(sumLow);
  endproperty
  a_offset_added: assert property (p_offset_added)
    else $error("offset not applied to pixel");

  property p_clamp_low;
    stgIf.valid && !stgIf.sat && sum[13] |=> pixData == 12'h000;
  endproperty
  a_clamp_low: assert property (p_clamp_low)
    else $error("negative pixel not clamped to zero");

  property p_std8_step;
    (VARIANT == bls_pkg::BLS_VAR_STD) && !r_q.actWide
      |-> stepSh == 3'h4;
  endproperty
  a_std8_step: assert property (p_std8_step)
    else $error("standard narrow step not sixteen");

  property p_latency;
    adcValid |-> ##2 pixValid;
  endproperty
  a_latency: assert property (p_latency)
    else $error("pixel lost in the stage");

  property p_shift2_window;
    adcValid && effWide && (effShift == 3'h2) && (adcData[11:10] == 2'h0)
      |=> stgIf.data == {$past(adcData[9:0]), 2'h0};
  endproperty
  a_shift2_window: assert property (p_shift2_window)
    else $error("shift by two window wrong");

  property p_shift3_window;
    adcValid && effWide && (effShift == 3'h3) && (adcData[11:9] == 3'h0)
      |=> stgIf.data == {$past(adcData[8:0]), 3'h0};
  endproperty
  a_shift3_window: assert property (p_shift3_window)
    else $error("shift by three window wrong");

  property p_shift4_window;
    adcValid && effWide && (effShift == 3'h4) && (adcData[11:8] == 4'h0)
      |=> stgIf.data == {$past(adcData[7:0]), 4'h0};
  endproperty
  a_shift4_window: assert property (p_shift4_window)
    else $error("shift by four window wrong");

  property p_clamp_high;
    stgIf.valid && !stgIf.sat && !sum[13] && (sum[12:0] > {1'b0, fullScale})
      |=> pixData == $past(fullScale);
  endproperty
  a_clamp_high: assert property (p_clamp_high)
    else $error("pixel above full scale not clamped");

  property p_red_step;
    (VARIANT == bls_pkg::BLS_VAR_RED) |-> stepSh == 3'h2;
  endproperty
  a_red_step: assert property (p_red_step)
    else $error("reduced variant step not four");

  property p_fine_step;
    (VARIANT == bls_pkg::BLS_VAR_FINE)
      |-> stepSh == (r_q.actWide ? 3'h2 : 3'h6);
  endproperty
  a_fine_step: assert property (p_fine_step)
    else $error("fine variant step wrong");

endmodule // bls_black_level_shift

// ===== bls_adc_model.sv
// Image sensor ADC model feeding 12-bit samples to the stage
module bls_adc_model (
  // Clock
  input  wire logic   clk,
  // Sample stream
  output logic        adcValid,
  output logic        adcSof,
  output logic [11:0] adcData
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    adcValid = 1'b0;
    adcSof   = 1'b0;
    adcData  = 12'h000;
  end

  // ==========================================================
  // One sample, then gap idle cycles
  // Readings past the shift limit only where a scenario asks
  task automatic send(input logic [11:0] d, input logic s, input int gap);
    @(posedge clk);
    adcValid <= 1'b1;
    adcSof   <= s;
    adcData  <= d;
    // Idle data toggles so a stale sample never passes for a live one
    repeat (gap) begin
      @(posedge clk);
      adcValid <= 1'b0;
      adcSof   <= 1'b0;
      adcData  <= ~adcData;
    end
  endtask
endmodule // bls_adc_model

// ===== bls_black_level_shift_tb_top.sv
// Self-checking bench of the black level and digital shift stage
module bls_black_level_shift_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [9:0] BLREF = 10'h020;

  logic        clk;
  logic        nrst;
  logic [7:0]  regAddr;
  logic [31:0] regWdata;
  logic        regWr;
  logic        regRd;
  logic [31:0] regRdata [3];
  logic        adcValid;
  logic        adcSof;
  logic [11:0] adcData;
  logic        pixValid [3];
  logic        pixSof [3];
  logic [11:0] pixData [3];
  int          bad_count;
  int          compares;
  int          cyc;
  logic [2:0]  shSh;
  logic [2:0]  acSh;
  logic        shWd;
  logic        acWd;
  logic [9:0]  shBl;
  logic [9:0]  acBl;
  logic [36:0] eq[$];
  logic [36:0] eRow;
  int          tq[$];

  // One stage per variant, all fed the same bus and sample stream
  for (genvar g = 0; g < 3; g++) begin : g_var
    bls_black_level_shift #(
      .VARIANT(bls_pkg::bls_variant_t'(g)),
      .BL_REF (BLREF)
    ) i_dut (.clk(clk), .nrst(nrst), .regAddr(regAddr), .regWdata(regWdata),
      .regWr(regWr), .regRd(regRd), .regRdata(regRdata[g]),
      .adcValid(adcValid), .adcSof(adcSof), .adcData(adcData),
      .pixValid(pixValid[g]), .pixSof(pixSof[g]), .pixData(pixData[g]));
  end

  bls_adc_model i_adc (.clk(clk), .adcValid(adcValid), .adcSof(adcSof),
    .adcData(adcData));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ==========================================================
  // Checking and reporting
  task automatic check(input string n, input logic [31:0] s,
                       input logic [31:0] e);
    compares++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask

  task automatic final_report();
    $display("Compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Variant index: 0 standard, 1 reduced range, 2 fine step
  function automatic logic [9:0] blc(input int vr, input logic [9:0] b);
    int mx;
    mx = (vr == 0) ? 255 : (vr == 1) ? 64 : 1023;
    return (int'(b) > mx) ? mx[9:0] : b;
  endfunction

  function automatic logic [31:0] stv(input int vr);
    logic [1:0] vc;
    vc = vr[1:0];
    return {6'h00, vc, 6'h00, blc(vr, acBl), 1'b0,
            ((vr == 1) ? 3'h0 : acSh), 3'h0, acWd};
  endfunction

  function automatic logic [11:0] expv(input logic [11:0] a, input int vr);
    logic [15:0] v;
    int          r;
    int          fs;
    int          st;
    v  = {4'h0, a} << ((vr == 1) ? 3'h0 : acSh);
    fs = acWd ? 4095 : 255;
    if (vr == 1) st = 2;
    else if (vr == 0) st = acWd ? 0 : 4;
    else st = acWd ? 2 : 6;
    if (v[15:12] != 4'h0) return fs[11:0];
    r = acWd ? int'(v[11:0]) : int'(v[11:4]);
    r = r + ((int'(blc(vr, acBl)) - int'(BLREF)) >>> st);
    r = (r < 0) ? 0 : (r > fs) ? fs : r;
    return r[11:0];
  endfunction

  always @(posedge clk) begin
    cyc++;
    if (cyc > 20000) begin
      bad_count++;
      final_report();
    end else if (nrst === 1'b1) begin
      if (adcValid === 1'b1) tq.push_back(cyc);
      if ({pixValid[2], pixValid[1], pixValid[0]} !== 3'h0) begin
        if (eq.size() == 0) begin
          check("spare pixValid", 1, 0);
        end else begin
          eRow = eq.pop_front();
          check("latency", cyc - tq.pop_front(), 2);
          for (int v = 0; v < 3; v++) begin
            check($sformatf("pixel %0d", v),
                  {pixValid[v], pixSof[v], pixData[v]},
                  {1'b1, eRow[36], eRow[12*v +: 12]});
          end
        end
      end
    end
  end

  // ==========================================================
  // Bus and stream tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regWr    <= 1'b1;
    regAddr  <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  // Expected words packed as {fine, reduced, standard}
  task automatic rd(input logic [7:0] a, input logic [95:0] e,
                    input string n);
    @(posedge clk);
    regRd   <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    @(posedge clk);
    for (int v = 0; v < 3; v++) begin
      check(n, regRdata[v], e[32*v +: 32]);
    end
    @(posedge clk);
    for (int v = 0; v < 3; v++) begin
      check({n, " idle"}, regRdata[v], 32'h0000_0000);
    end
  endtask

  task automatic setc(input logic w, input logic [2:0] s);
    wr(bls_pkg::ADDR_CTRL, {25'h0, s, 3'h0, w});
    shWd = w;
    shSh = (s > 3'h4) ? 3'h4 : s;
  endtask

  task automatic setb(input logic [9:0] b);
    wr(bls_pkg::ADDR_BLACK, {22'h0, b});
    shBl = b;
  endtask

  task automatic px(input logic [11:0] a, input logic s, input int gap);
    if (s) begin
      acSh = shSh;
      acWd = shWd;
      acBl = shBl;
    end
    eq.push_back({s, expv(a, 2), expv(a, 1), expv(a, 0)});
    i_adc.send(a, s, gap);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs();
    rd(bls_pkg::ADDR_CTRL, {3{32'h0000_0000}}, "ctrl reset");
    rd(bls_pkg::ADDR_BLACK, {3{32'h0000_0000}}, "black reset");
    rd(bls_pkg::ADDR_STATUS, {32'h0200_0000, 32'h0100_0000, 32'h0000_0000},
       "status reset");
    wr(8'h0c, 32'hffff_ffff);
    rd(8'h0c, {3{32'h0000_0000}}, "unmapped");
    setc(1'b1, 3'h7);
    rd(bls_pkg::ADDR_CTRL, {32'h0000_0041, 32'h0000_0001, 32'h0000_0041},
       "ctrl clamp");
    setb(10'h3ff);
    rd(bls_pkg::ADDR_BLACK, {32'h0000_03ff, 32'h0000_0040, 32'h0000_00ff},
       "black clamp");
  endtask

  task automatic t_shift(input logic w);
    setb(BLREF);
    for (int s = 0; s <= 4; s++) begin
      setc(w, 3'(s));
      px(12'h07b, 1'b1, 0);
      px(12'hfff >> s, 1'b0, 0);
      if (s > 0) px(12'h001 << (12 - s), 1'b0, 0);
      px(12'h000, 1'b0, 1);
    end
  endtask

  task automatic t_black();
    logic [9:0] bl [6] = '{BLREF + 10'h010, BLREF + 10'h001,
                           BLREF - 10'h001, 10'h000, 10'h0ff, 10'h3ff};
    for (int w = 0; w < 2; w++) begin
      for (int i = 0; i < 6; i++) begin
        setc(1'(w), 3'h0);
        setb(bl[i]);
        px(12'h100, 1'b1, 0);
        px(12'h010, 1'b0, 0);
        px(12'hfff, 1'b0, 1);
      end
    end
  endtask

  task automatic t_frame();
    setc(1'b1, 3'h0);
    setb(BLREF);
    px(12'h050, 1'b1, 1);
    setc(1'b1, 3'h2);
    setb(BLREF + 10'h004);
    px(12'h050, 1'b0, 1);
    px(12'h050, 1'b1, 1);
    rd(bls_pkg::ADDR_STATUS, {stv(2), stv(1), stv(0)}, "status");
  endtask

  initial begin
    nrst      = 1'b0;
    regWr     = 1'b0;
    regRd     = 1'b0;
    regAddr   = 8'h00;
    regWdata  = 32'h0000_0000;
    bad_count = 0;
    compares  = 0;
    cyc       = 0;
    {shSh, acSh, shWd, acWd, shBl, acBl} = '0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    t_regs();
    t_shift(1'b0);
    t_shift(1'b1);
    t_black();
    t_frame();
    repeat (5) @(posedge clk);
    check("pending pixels", eq.size(), 0);
    final_report();
  end
endmodule // bls_black_level_shift_tb_top
